/* File: charger_regs.svh */
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH

// Register offsets
`define ADDR_SEC_LIMIT   8'h0F
`define ADDR_HOLD        8'h10
`define ADDR_CYCLE       8'h11
`define ADDR_ALERT       8'h12
`define ADDR_STATUS      8'h13

// Field positions
`define CODE_MSB         7
`define CODE_LSB         1
`define LIMIT2_MSB       6
`define LIMIT2_LSB       0
`define OCP_MSB          6
`define OCP_LSB          3
`define SKIP_BIT         1
`define RSV_BIT0         0
`define RSV_BIT7         7

// Power-on field values
`define HOLD_RESET       7'h03
`define CYCLE_RESET      7'h07
`define LIMIT2_RESET     7'h1E
`define OCP_RESET        4'hE
`define SKIP_RESET       1'b1

// Reserved bit read values
`define HOLD_RSV0        1'b1
`define CYCLE_RSV0       1'b0
`define ALERT_RSV0       1'b1
`define RSV_ZERO         1'b0

// Alert threshold scaling in mA
`define OCP_OFFSET_MA    14'h2BC
`define OCP_STEP_MA      14'h320

// Timing
`define CLK_PERIOD_NS    10
`define LIMIT_STEP_NS    100000

// Serial bus
`define DEV_ADDR_DEFAULT 7'h5C
`define BYTE_BITS        4'h8
`define LAST_BIT         4'h7

`endif

/* File: charger_pkg.sv */
package charger_pkg;

    typedef enum logic [9:0] {
        ST_IDLE      = 10'h001,
        ST_ADDR      = 10'h002,
        ST_ACK_ADDR  = 10'h004,
        ST_REG       = 10'h008,
        ST_ACK_REG   = 10'h010,
        ST_WDATA     = 10'h020,
        ST_ACK_WDATA = 10'h040,
        ST_RDATA     = 10'h080,
        ST_RACK      = 10'h100,
        ST_RACK_OK   = 10'h200
    } serial_state_t;

    typedef logic [6:0] time_code_t;

endpackage

/* File: limit_phase_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface limit_phase_if;
    import charger_pkg::*;
    time_code_t hold_code;
    time_code_t cycle_code;
    logic       secondary_active;

    modport ctrl  (output hold_code, output cycle_code, input secondary_active);
    modport timer (input hold_code, input cycle_code, output secondary_active);
endinterface

`default_nettype wire

/* File: limit_phase_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charger_regs.svh"

module limit_phase_timer
    import charger_pkg::*;
#(
    parameter int TICK_CYCLES = `LIMIT_STEP_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic      clock_in,
    input  wire logic      rst_in,
    // Codes in, phase out
    limit_phase_if.timer   lp
);

    logic [15:0] div_cnt;
    logic [8:0]  unit_cnt;
    logic        secondary_q;

    // Step counts in 100 us units
    wire logic        tick        = (div_cnt == 16'(TICK_CYCLES - 1));
    wire logic [8:0]  hold_units  = {1'b0, lp.hold_code, 1'b1};
    wire logic [8:0]  cycle_units = {1'b0, lp.cycle_code, 1'b0} + 9'h002;
    wire logic [8:0]  unit_inc    = unit_cnt + 9'h001;
    wire logic [8:0]  next_unit   = !tick ? unit_cnt : (unit_inc >= cycle_units) ? 9'h000 : unit_inc;
    wire logic [15:0] next_div    = tick ? 16'h0000 : div_cnt + 16'h0001;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            div_cnt     <= 16'h0000;
            unit_cnt    <= 9'h000;
            secondary_q <= 1'b1;
        end else begin
            div_cnt     <= next_div;
            unit_cnt    <= next_unit;
            secondary_q <= (next_unit < hold_units);
        end
    end

    assign lp.secondary_active = secondary_q;

    property p_cycle_wrap;
        @(posedge clock_in) disable iff (rst_in)
        (tick && unit_inc >= cycle_units) |=> (unit_cnt == 9'h000) && secondary_q;
    endproperty
    a_cycle_wrap: assert property (p_cycle_wrap) else $error("limit cycle did not restart");

    property p_primary_after_hold;
        @(posedge clock_in) disable iff (rst_in)
        (tick && unit_inc == hold_units && unit_inc < cycle_units && $stable(lp.hold_code))
            |=> !secondary_q;
    endproperty
    a_primary_after_hold: assert property (p_primary_after_hold) else $error("hold time overran");

endmodule

`default_nettype wire

/* File: charger_limit_timing_status_regs.sv */
// Behaviour
// - The hold field is seven bits of 200 us steps over a 100 us offset, reset to 700 us.
// - The cycle field is seven bits of 200 us steps over a 200 us offset, reset to 1600 us.
// - The hot alert rises while input current exceeds 700 mA plus 800 mA per step of bits 6 to 3, reset 11.9 A.
// - Bit 1 of the alert register enables light-load pulse skipping, set after reset.
// - Status bit 7 reads the battery undervoltage lockout, zero after reset.
// - Status bit 6 reads the system undervoltage condition, zero after reset.
// - Status bit 4 reads one while either input limiting loop is active, zero after reset.
// - Status bits 3:2 give the charge phase, bit 1 input power good, bit 0 outside minimum regulation.
// - The secondary current limit is seven bits of 50 mA with no offset, reset to 1.5 A.
`timescale 1ns/1ps
`default_nettype none
`include "charger_regs.svh"

module charger_limit_timing_status_regs
    import charger_pkg::*;
#(
    parameter int         TICK_CYCLES    = `LIMIT_STEP_NS / `CLK_PERIOD_NS,
    parameter logic [6:0] DEVICE_ADDRESS = `DEV_ADDR_DEFAULT
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // Serial bus
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    // Status sources
    input  wire logic        battery_undervoltage_flag_in,
    input  wire logic        system_undervoltage_flag_in,
    input  wire logic        input_voltage_limiting_loop_in,
    input  wire logic        input_current_limiting_loop_in,
    input  wire logic [1:0]  charge_phase_in,
    input  wire logic        input_power_good_in,
    input  wire logic        system_outside_min_regulation_in,
    // Input current measurement
    input  wire logic [13:0] input_current_ma_in,
    // Controls
    output logic             processor_hot_alert_out,
    output logic             light_load_pulse_skip_enable_out,
    output logic [6:0]       secondary_input_current_limit_out,
    output logic             secondary_limit_active_out
);

    serial_state_t state;
    serial_state_t next_state;
    logic [3:0]    bit_cnt;
    logic [3:0]    next_cnt;
    logic [7:0]    shift;
    logic [7:0]    next_shift;
    logic [7:0]    ptr;
    logic [7:0]    next_ptr;
    logic          rw;
    logic          next_rw;
    logic          wr_en;
    logic          scl_q;
    logic          scl_d;
    logic          sda_q;
    logic          sda_d;

    time_code_t    hold_code;
    time_code_t    cycle_code;
    logic [6:0]    limit2_code;
    logic [3:0]    input_overcurrent_alert_level;
    logic          skip_en;
    logic          alert_q;
    logic [7:0]    status_q;

    limit_phase_if lp ();

    // Register read image
    function automatic logic [7:0] read_reg(input logic [7:0] a);
        case (a)
            `ADDR_SEC_LIMIT: read_reg = {`RSV_ZERO, limit2_code};
            `ADDR_HOLD:      read_reg = {hold_code, `HOLD_RSV0};
            `ADDR_CYCLE:     read_reg = {cycle_code, `CYCLE_RSV0};
            `ADDR_ALERT:     read_reg = {`RSV_ZERO, input_overcurrent_alert_level, `RSV_ZERO, skip_en, `ALERT_RSV0};
            `ADDR_STATUS:    read_reg = status_q;
            default:         read_reg = 8'h00;
        endcase
    endfunction

    // Bus edge and condition decode
    wire logic scl_rise  = scl_q & ~scl_d;
    wire logic scl_fall  = ~scl_q & scl_d;
    wire logic bus_start = scl_q & scl_d & sda_d & ~sda_q;
    wire logic bus_stop  = scl_q & scl_d & ~sda_d & sda_q;
    wire logic byte_done = (bit_cnt == `BYTE_BITS);
    wire logic addr_hit  = (shift[7:1] == DEVICE_ADDRESS);
    wire logic [7:0] ptr_inc = ptr + 8'h01;

    // Write strobes
    wire logic       wr_limit2 = wr_en && (ptr == `ADDR_SEC_LIMIT);
    wire logic       wr_hold   = wr_en && (ptr == `ADDR_HOLD);
    wire logic       wr_cycle  = wr_en && (ptr == `ADDR_CYCLE);
    wire logic       wr_alert  = wr_en && (ptr == `ADDR_ALERT);
    wire time_code_t wr_code   = shift[`CODE_MSB:`CODE_LSB];
    wire logic       wr_skip   = shift[`SKIP_BIT];

    // Status image and alert threshold
    wire logic       power_path_limiting_flag = input_voltage_limiting_loop_in | input_current_limiting_loop_in;
    wire logic [7:0] status_image = {battery_undervoltage_flag_in, system_undervoltage_flag_in, `RSV_ZERO,
                                     power_path_limiting_flag, charge_phase_in, input_power_good_in,
                                     system_outside_min_regulation_in};
    wire logic [13:0] ocp_threshold_ma = `OCP_OFFSET_MA
                                         + {10'h000, input_overcurrent_alert_level} * `OCP_STEP_MA;

    always_comb begin
        next_state = state;
        next_cnt   = bit_cnt;
        next_shift = shift;
        next_ptr   = ptr;
        next_rw    = rw;
        wr_en      = 1'b0;
        if (bus_stop) begin
            next_state = ST_IDLE;
        end else if (bus_start) begin
            next_state = ST_ADDR;
            next_cnt   = 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise && !byte_done) begin
                        next_shift = {shift[6:0], sda_q};
                        next_cnt   = bit_cnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        next_cnt = 4'h0;
                        if (state == ST_ADDR) begin
                            next_rw    = shift[0];
                            next_state = addr_hit ? ST_ACK_ADDR : ST_IDLE;
                        end else if (state == ST_REG) begin
                            next_ptr   = shift;
                            next_state = ST_ACK_REG;
                        end else begin
                            wr_en      = 1'b1;
                            next_state = ST_ACK_WDATA;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        next_shift = read_reg(ptr);
                        next_state = rw ? ST_RDATA : ST_REG;
                    end
                end
                ST_ACK_REG: begin
                    if (scl_fall) begin
                        next_state = ST_WDATA;
                    end
                end
                ST_ACK_WDATA: begin
                    if (scl_fall) begin
                        next_ptr   = ptr_inc;
                        next_state = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        next_shift = {shift[6:0], 1'b0};
                        next_cnt   = (bit_cnt == `LAST_BIT) ? 4'h0 : bit_cnt + 4'h1;
                        next_state = (bit_cnt == `LAST_BIT) ? ST_RACK : ST_RDATA;
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        next_state = sda_q ? ST_IDLE : ST_RACK_OK;
                    end
                end
                ST_RACK_OK: begin
                    if (scl_fall) begin
                        next_ptr   = ptr_inc;
                        next_shift = read_reg(ptr_inc);
                        next_state = ST_RDATA;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            {scl_q, scl_d, sda_q, sda_d} <= 4'hF;
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            ptr     <= 8'h00;
            rw      <= 1'b0;
        end else begin
            {scl_q, scl_d, sda_q, sda_d} <= {scl_in, scl_q, sda_in, sda_q};
            state   <= next_state;
            bit_cnt <= next_cnt;
            shift   <= next_shift;
            ptr     <= next_ptr;
            rw      <= next_rw;
        end
    end

    // Configuration fields, loaded by power-on reset and by bus writes
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hold_code                     <= `HOLD_RESET;
            cycle_code                    <= `CYCLE_RESET;
            limit2_code                   <= `LIMIT2_RESET;
            input_overcurrent_alert_level <= `OCP_RESET;
            skip_en                       <= `SKIP_RESET;
        end else begin
            if (wr_limit2) limit2_code <= shift[`LIMIT2_MSB:`LIMIT2_LSB];
            if (wr_hold) hold_code <= wr_code;
            if (wr_cycle) cycle_code <= wr_code;
            if (wr_alert) input_overcurrent_alert_level <= shift[`OCP_MSB:`OCP_LSB];
            if (wr_alert) skip_en <= wr_skip;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            alert_q  <= 1'b0;
            status_q <= 8'h00;
        end else begin
            alert_q  <= (input_current_ma_in > ocp_threshold_ma);
            status_q <= status_image;
        end
    end

    assign lp.hold_code  = hold_code;
    assign lp.cycle_code = cycle_code;

    limit_phase_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .lp       (lp.timer)
    );

    assign sda_out                           = 1'b0;
    assign sda_oe_out                        = (state == ST_ACK_ADDR) || (state == ST_ACK_REG)
                                               || (state == ST_ACK_WDATA) || ((state == ST_RDATA) && !shift[7]);
    assign processor_hot_alert_out           = alert_q;
    assign light_load_pulse_skip_enable_out  = skip_en;
    assign secondary_input_current_limit_out = limit2_code;
    assign secondary_limit_active_out        = lp.secondary_active;

    property p_hold_write;
        @(posedge clock_in) disable iff (rst_in) wr_hold |=> (hold_code == $past(wr_code));
    endproperty
    a_hold_write: assert property (p_hold_write) else $error("hold field not written");

    property p_power_on;
        @(posedge clock_in) $fell(rst_in) |-> (cycle_code == `CYCLE_RESET) && (hold_code == `HOLD_RESET);
    endproperty
    a_power_on: assert property (p_power_on) else $error("timing fields wrong after reset");

    property p_alert_set;
        @(posedge clock_in) disable iff (rst_in)
        (input_current_ma_in > ocp_threshold_ma) |=> processor_hot_alert_out;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("hot alert missing");

    property p_alert_clear;
        @(posedge clock_in) disable iff (rst_in)
        (input_current_ma_in <= ocp_threshold_ma) |=> !processor_hot_alert_out;
    endproperty
    a_alert_clear: assert property (p_alert_clear) else $error("hot alert spurious");

    property p_skip_write;
        @(posedge clock_in) disable iff (rst_in)
        wr_alert |=> (light_load_pulse_skip_enable_out == $past(wr_skip));
    endproperty
    a_skip_write: assert property (p_skip_write) else $error("skip enable not written");

    property p_status_read;
        @(posedge clock_in) disable iff (rst_in)
        ((state == ST_ACK_ADDR) && scl_fall && rw && (ptr == `ADDR_STATUS)) |=> (shift == $past(status_q));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status byte mismatch");

    property p_limit2_reset;
        @(posedge clock_in) $fell(rst_in) |-> (secondary_input_current_limit_out == `LIMIT2_RESET);
    endproperty
    a_limit2_reset: assert property (p_limit2_reset) else $error("limit two reset wrong");

    property p_reserved_read;
        @(posedge clock_in) disable iff (rst_in)
        ((state == ST_ACK_ADDR) && scl_fall && rw && (ptr == `ADDR_ALERT))
            |=> (shift[`RSV_BIT0] == `ALERT_RSV0) && (shift[`RSV_BIT7] == `RSV_ZERO);
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved bits wrong");

    property p_addr_ack;
        @(posedge clock_in) disable iff (rst_in)
        ((state == ST_ADDR) && scl_fall && byte_done && addr_hit && !bus_stop) |=> sda_oe_out [*1] ##1 1'b1;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

endmodule

`default_nettype wire

/* File: serial_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charger_regs.svh"

module serial_host_model (
    // Clock
    input  wire logic       clock_in,
    // Serial bus
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            sda_low_out,
    // Read results
    output logic [7:0]      rd_data_out,
    output logic            rd_valid_out
);
    initial begin
        scl_out      = 1'b1;
        sda_low_out  = 1'b0;
        rd_data_out  = 8'h00;
        rd_valid_out = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // Data moves only while the clock is low
    task automatic put_bit(input logic b);
        sda_low_out <= !b;
        wait_clk(3);
        scl_out <= 1'b1;
        wait_clk(5);
        scl_out <= 1'b0;
        wait_clk(2);
    endtask

    // Released line floats high through the pull-up
    task automatic get_bit(output logic b);
        sda_low_out <= 1'b0;
        wait_clk(3);
        scl_out <= 1'b1;
        wait_clk(3);
        b = sda_in;
        wait_clk(2);
        scl_out <= 1'b0;
        wait_clk(2);
    endtask

    task automatic start_cond;
        sda_low_out <= 1'b0;
        wait_clk(2);
        scl_out <= 1'b1;
        wait_clk(5);
        sda_low_out <= 1'b1;
        wait_clk(5);
        scl_out <= 1'b0;
        wait_clk(2);
    endtask

    task automatic stop_cond;
        sda_low_out <= 1'b1;
        wait_clk(3);
        scl_out <= 1'b1;
        wait_clk(5);
        sda_low_out <= 1'b0;
        wait_clk(5);
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ok = !a;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] rg, input logic [7:0] d, output logic ok);
        logic a1, a2, a3;
        start_cond();
        put_byte({dev, 1'b0}, a1);
        put_byte(rg, a2);
        put_byte(d, a3);
        stop_cond();
        ok = a1 & a2 & a3;
    endtask

    // Pointer write, repeated start, one byte ended by a not-acknowledge
    task automatic read_reg(input logic [7:0] rg, output logic ok);
        logic       a1, a2, a3;
        logic [7:0] d;
        start_cond();
        put_byte({`DEV_ADDR_DEFAULT, 1'b0}, a1);
        put_byte(rg, a2);
        start_cond();
        put_byte({`DEV_ADDR_DEFAULT, 1'b1}, a3);
        get_byte(1'b1, d);
        stop_cond();
        ok = a1 & a2 & a3;
        rd_data_out  <= d;
        rd_valid_out <= 1'b1;
        wait_clk(1);
        rd_valid_out <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: charger_limit_timing_status_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charger_regs.svh"

module charger_limit_timing_status_regs_bench;
    localparam int TICKS = 4;
    logic        clock_in = 1'b0;
    logic        rst_in   = 1'b1;
    logic        scl, host_low, sda_oe, sda_drv, rd_valid;
    logic [7:0]  rd_data;
    wire logic   sda_line;
    logic        bat_uv = 1'b0, sys_uv = 1'b0, v_loop = 1'b0, i_loop = 1'b0, good = 1'b0, min_reg = 1'b0;
    logic [1:0]  phase_in = 2'h0;
    logic [13:0] current = 14'h0000;
    logic        alert, skip, sec;
    logic [6:0]  lim2;
    logic        ok;
    logic [7:0]  d, r;
    int          errors = 0;
    int          comparisons = 0;
    logic [7:0]  exp_q[$];

    assign sda_line = !(sda_oe || host_low);
    always #5 clock_in = ~clock_in;

    charger_limit_timing_status_regs #(.TICK_CYCLES(TICKS)) uut (
        .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .battery_undervoltage_flag_in(bat_uv), .system_undervoltage_flag_in(sys_uv),
        .input_voltage_limiting_loop_in(v_loop), .input_current_limiting_loop_in(i_loop),
        .charge_phase_in(phase_in), .input_power_good_in(good), .system_outside_min_regulation_in(min_reg),
        .input_current_ma_in(current), .processor_hot_alert_out(alert),
        .light_load_pulse_skip_enable_out(skip), .secondary_input_current_limit_out(lim2),
        .secondary_limit_active_out(sec));

    serial_host_model host (
        .clock_in(clock_in), .sda_in(sda_line), .scl_out(scl), .sda_low_out(host_low),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid));

    task automatic stop_test;
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] expect_v);
        comparisons++;
        if (seen !== expect_v) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, expect_v);
        end
    endtask

    task automatic rd(input logic [7:0] rg, input logic [7:0] expect_v);
        exp_q.push_back(expect_v);
        host.read_reg(rg, ok);
        check(ok, 8'h01);
    endtask

    task automatic wr(input logic [7:0] rg, input logic [7:0] v);
        host.write_reg(`DEV_ADDR_DEFAULT, rg, v, ok);
        check(ok, 8'h01);
    endtask

    // Read-back shape of each writable register
    function automatic logic [7:0] shape(input int k, input logic [7:0] v);
        case (k)
            0: shape = {1'b0, v[6:0]};
            1: shape = {v[7:1], 1'b1};
            2: shape = {v[7:1], 1'b0};
            default: shape = {1'b0, v[6:3], 1'b0, v[1], 1'b1};
        endcase
    endfunction

    // Four whole cycles counted, so the phase of the window does not matter
    task automatic limit_phase(input logic [6:0] h, input logic [6:0] c);
        int   len, hi, rises, on;
        logic prev;
        wr(8'h10, {h, 1'b1});
        wr(8'h11, {c, 1'b0});
        len = (2 * c + 2) * TICKS;
        on = (2 * h + 1 < 2 * c + 2) ? (2 * h + 1) * TICKS : len;
        repeat (len) @(posedge clock_in);
        prev = sec;
        hi = 0;
        rises = 0;
        repeat (4 * len) begin
            @(posedge clock_in);
            if (sec === 1'b1) hi++;
            if (sec === 1'b1 && prev === 1'b0) rises++;
            prev = sec;
        end
        check(8'(hi), 8'(4 * on));
        check(8'(rises), (on < len) ? 8'h04 : 8'h00);
    endtask

    always @(posedge clock_in) begin
        if (rd_valid === 1'b1) check(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
    end

    initial begin
        repeat (60000) @(posedge clock_in);
        errors++;
        stop_test();
    end

    initial begin
        void'($urandom(61));
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        check(lim2, 8'h1E);
        check(skip, 8'h01);
        check(alert, 8'h00);
        check(sec, 8'h01);
        check(sda_drv, 8'h00);
        rd(8'h0F, 8'h1E);
        rd(8'h10, 8'h07);
        rd(8'h11, 8'h0E);
        rd(8'h12, 8'h73);
        rd(8'h13, 8'h00);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr(8'h0F + 8'(k), d);
            if (k == 0) check(lim2, {1'b0, d[6:0]});
            rd(8'h0F + 8'(k), shape(k, d));
        end
        wr(8'h13, 8'hFF);
        rd(8'h13, 8'h00);
        rd(8'h20, 8'h00);
        host.write_reg(`DEV_ADDR_DEFAULT ^ 7'h01, 8'h12, 8'h00, ok);
        check(ok, 8'h00);
        rd(8'h12, shape(3, d));
        for (int p = 0; p < 4; p++) begin
            r = 8'($urandom);
            @(posedge clock_in);
            bat_uv <= r[0];
            sys_uv <= r[1];
            v_loop <= r[2];
            i_loop <= r[3];
            good <= r[4];
            min_reg <= r[5];
            phase_in <= 2'(p);
            rd(8'h13, {r[0], r[1], 1'b0, r[2] | r[3], 2'(p), r[4], r[5]});
        end
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h0F : 8'($urandom % 16);
            wr(8'h12, {1'b0, d[3:0], 1'b0, d[0], 1'b1});
            check(skip, {7'h00, d[0]});
            @(posedge clock_in);
            current <= 14'(700 + 800 * d[3:0]);
            repeat (3) @(posedge clock_in);
            check(alert, 8'h00);
            current <= 14'(701 + 800 * d[3:0]);
            repeat (3) @(posedge clock_in);
            check(alert, 8'h01);
            current <= 14'h0000;
        end
        limit_phase(7'h01, 7'h03);
        limit_phase(7'h00, 7'h01);
        limit_phase(7'h03, 7'h01);
        repeat (5) @(posedge clock_in);
        stop_test();
    end
endmodule

`default_nettype wire
